// ---- hdl/ssp_core.sv ----
// Synchronous serial port core: master or slave, three frame formats,
// transmit and receive buffers, interrupt status and mask.
// Assumes configuration is static while a frame runs and that the
// link pins are asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none

module ssp_core #(
  parameter int DATA_W       = ssp_pkg::DATA_W,
  parameter int FIFO_DEPTH   = ssp_pkg::FIFO_DEPTH,
  parameter int TIMEOUT_BITS = ssp_pkg::TIMEOUT_BITS
) (
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire ssp_pkg::ssp_cfg_t     CFG,
  input  wire ssp_pkg::ssp_irq_t     IRQ_MASK,
  input  wire logic                  TX_WVALID,
  input  wire logic [DATA_W-1:0]     TX_WDATA,
  output logic                       TX_WREADY,
  output logic                       RX_RVALID,
  output logic [DATA_W-1:0]          RX_RDATA,
  input  wire logic                  RX_RREADY,
  input  wire logic                  TIMEOUT_CLR,
  input  wire logic                  OVERRUN_CLR,
  output ssp_pkg::ssp_irq_t          RAW_STATUS,
  output ssp_pkg::ssp_irq_t          MASKED_STATUS,
  output logic                       IRQ,
  output logic                       TX_DMA_REQ,
  output logic                       BUSY,
  input  wire ssp_pkg::ssp_pin_in_t  PINS_I,
  output ssp_pkg::ssp_pin_out_t      PINS_O
);

  // ----------------------------------------------------------------
  // Local sizes
  // ----------------------------------------------------------------
  localparam int LW  = $clog2(FIFO_DEPTH + 1);
  localparam int TOW = $clog2(TIMEOUT_BITS + 1);
  localparam int HW  = $clog2(ssp_pkg::HIST_DEPTH);
  localparam int CW  = $clog2(ssp_pkg::HIST_DEPTH + 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ssp_pkg::ssp_seq_t                    seq;     // Master sequencer
    logic                                 half;    // Second half of slot
    logic [4:0]                           slot;    // Bit slot in frame
    logic [6:0]                           psc_cnt; // First divider stage
    logic [7:0]                           rate_cnt;// Second divider stage
    logic                                 tick_ph; // Half-tick parity
    logic [DATA_W-1:0]                    sh_tx;   // Transmit shifter
    logic [DATA_W-1:0]                    sh_rx;   // Receive shifter
    logic [DATA_W-1:0]                    hold;    // Received word
    logic                                 hold_v;  // Hold awaits buffer
    logic                                 sclk_o;
    logic                                 fsel_o;
    logic                                 txd_o;
    logic                                 sl_act;  // Slave pulse frame on
    logic [4:0]                           sl_cnt;  // Slave bits sampled
    logic [TOW-1:0]                       to_cnt;  // Idle bit periods
    logic                                 to_flag;
    logic                                 ov_flag;
    logic [ssp_pkg::HIST_DEPTH-1:0][DATA_W-1:0] hist; // Recent writes
    logic [HW-1:0]                        hptr;
    logic [CW-1:0]                        hcnt;
    logic                                 sclk_m;  // Synchroniser stages
    logic                                 sclk_s;
    logic                                 sclk_d;
    logic                                 fs_m;
    logic                                 fs_s;
    logic                                 fs_d;
    logic                                 rxd_m;
    logic                                 rxd_s;
  } ssp_st_t;

  ssp_st_t r;
  ssp_st_t n;

  // Buffer handshakes
  logic              tx_valid;
  logic [DATA_W-1:0] tx_data;
  logic              tx_pop;
  logic              rx_room;
  logic [LW-1:0]     tx_level;
  logic [LW-1:0]     rx_level;

  // Decoded configuration
  logic              pulse;
  logic              cmd;
  logic              ecpol;
  logic              ecpha;
  logic              lvl_a;
  logic [4:0]        nbits;
  logic [4:0]        nslots;
  logic [6:0]        psc_top;
  logic [DATA_W-1:0] rmask;

  // Per-cycle events
  logic              half_tick;
  logic              bit_tick;
  logic              rx_bit;
  logic              rise;
  logic              fall;
  logic              samp_edge;
  logic              shft_edge;
  logic              sel;
  logic              load;
  logic              clk_act;
  logic [DATA_W-1:0] src_word;
  logic [DATA_W-1:0] ld_word;

  // ----------------------------------------------------------------
  // Buffers
  // ----------------------------------------------------------------
  // Transmit buffer; TX_WREADY low is the back-pressure to the writer
  ssp_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_txf (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_valid  (TX_WVALID),
    .in_data   (TX_WDATA),
    .in_ready  (TX_WREADY),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_pop),
    .level     (tx_level)
  );

  // Receive buffer; the reader stalls it by holding RX_RREADY low
  ssp_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_rxf (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_valid  (r.hold_v),
    .in_data   (r.hold),
    .in_ready  (rx_room),
    .out_valid (RX_RVALID),
    .out_data  (RX_RDATA),
    .out_ready (RX_RREADY),
    .level     (rx_level)
  );

  // ----------------------------------------------------------------
  // Format decode
  // ----------------------------------------------------------------
  // Pulse format behaves as polarity 0, phase 1; command as 0, 0
  assign pulse  = (CFG.fmt == ssp_pkg::FMT_PULSE);
  assign cmd    = (CFG.fmt == ssp_pkg::FMT_CMD);
  assign ecpol  = (CFG.fmt == ssp_pkg::FMT_SPI) & CFG.clock_polarity_bit;
  assign ecpha  = pulse | ((CFG.fmt == ssp_pkg::FMT_SPI) & CFG.clock_phase_bit);
  assign lvl_a  = ecpha ? ~ecpol : ecpol;  // Clock level in first half of a slot
  assign nbits  = 5'(CFG.size_m1) + 5'h01;
  assign nslots = cmd ? nbits + 5'(ssp_pkg::CMD_BITS + 1) : nbits;
  assign rmask  = {DATA_W{1'b1}} >> (5'(DATA_W) - nbits);
  // Halving the divisor gives half-periods; bit 0 is ignored (even only)
  assign psc_top = ((CFG.prescale_divisor < ssp_pkg::PSC_MIN) ?
                    ssp_pkg::PSC_MIN[7:1] : CFG.prescale_divisor[7:1]) - 7'h01;

  // Frame word aligned so its MSB leaves first
  function automatic logic [DATA_W-1:0] align(input logic [DATA_W-1:0] w,
                                              input logic c,
                                              input logic [4:0] nb);
    if (c) begin
      align = {w[ssp_pkg::CMD_BITS-1:0], {(DATA_W - ssp_pkg::CMD_BITS){1'b0}}};
    end else begin
      align = w << (5'(DATA_W) - nb);
    end
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n         = r;
    half_tick = 1'b0;
    tx_pop    = 1'b0;
    load      = 1'b0;

    // Pins pass two flops first; slave edge detection needs CLK >= 12x
    n.sclk_m = PINS_I.sclk;
    n.sclk_s = r.sclk_m;
    n.sclk_d = r.sclk_s;
    n.fs_m   = PINS_I.fsel;
    n.fs_s   = r.fs_m;
    n.fs_d   = r.fs_s;
    n.rxd_m  = PINS_I.rxd;
    n.rxd_s  = r.rxd_m;

    rise      = r.sclk_s & ~r.sclk_d;
    fall      = ~r.sclk_s & r.sclk_d;
    samp_edge = (ecpol == ecpha) ? rise : fall;
    shft_edge = (ecpol == ecpha) ? fall : rise;
    sel       = pulse ? r.sl_act : ~r.fs_s;
    rx_bit    = CFG.loopback ? r.txd_o : r.rxd_s;

    // Two-stage divider; one half_tick per half serial period
    if (!CFG.enable) begin
      n.psc_cnt  = '0;
      n.rate_cnt = '0;
      n.tick_ph  = 1'b0;
    end else if (r.psc_cnt >= psc_top) begin
      n.psc_cnt = '0;
      if (r.rate_cnt >= CFG.serial_clock_rate) begin
        n.rate_cnt = '0;
        half_tick  = 1'b1;
        n.tick_ph  = ~r.tick_ph;
      end else begin
        n.rate_cnt = r.rate_cnt + 8'h01;
      end
    end else begin
      n.psc_cnt = r.psc_cnt + 7'h01;
    end
    bit_tick = half_tick & r.tick_ph;

    // Remember the last eight accepted writes for slave underrun
    if (TX_WVALID && TX_WREADY) begin
      n.hist[r.hptr] = TX_WDATA;
      n.hptr         = r.hptr + HW'(1);
      if (r.hcnt != CW'(ssp_pkg::HIST_DEPTH)) begin
        n.hcnt = r.hcnt + CW'(1);
      end
    end
    // Oldest of the last eight sits at the write pointer
    if (r.hcnt == CW'(ssp_pkg::HIST_DEPTH)) begin
      src_word = tx_valid ? tx_data : r.hist[r.hptr];
    end else begin
      src_word = tx_valid ? tx_data : '0;
    end
    ld_word = align(tx_valid ? tx_data : src_word, cmd, nbits);

    // Hold register drains into the receive buffer the next cycle
    n.hold_v = 1'b0;

    // Master frame sequencer, advanced on half periods
    unique case (r.seq)
      ssp_pkg::SEQ_IDLE: begin
        n.sclk_o = ecpol;
        n.fsel_o = ~pulse;
        if (CFG.enable && CFG.master && tx_valid && half_tick) begin
          tx_pop   = 1'b1;
          n.sh_tx  = ld_word;
          n.txd_o  = ld_word[DATA_W-1];
          n.seq    = ssp_pkg::SEQ_LEAD;
          n.half   = 1'b0;
          n.fsel_o = pulse;
          if (pulse) begin
            n.sclk_o = 1'b1;  // Pulse starts on a rising edge
          end
        end
      end
      ssp_pkg::SEQ_LEAD: begin
        if (half_tick) begin
          if (pulse && !r.half) begin
            n.half   = 1'b1;
            n.sclk_o = 1'b0;
          end else begin
            n.seq    = ssp_pkg::SEQ_SLOT;
            n.half   = 1'b0;
            n.slot   = '0;
            n.sclk_o = lvl_a;
            if (pulse) begin
              n.fsel_o = 1'b0;
            end
          end
        end
      end
      ssp_pkg::SEQ_SLOT: begin
        if (half_tick) begin
          if (!r.half) begin
            // Mid-slot edge samples; command bits and the wait slot ignore input
            n.half   = 1'b1;
            n.sclk_o = ~lvl_a;
            if (!cmd || r.slot > 5'(ssp_pkg::CMD_BITS)) begin
              n.sh_rx = {r.sh_rx[DATA_W-2:0], rx_bit};
            end
          end else if (r.slot == nslots - 5'h01) begin
            n.seq    = ssp_pkg::SEQ_TAIL;
            n.sclk_o = ecpol;
            n.fsel_o = ~pulse;
          end else begin
            // Slot boundary is the drive edge
            n.slot   = r.slot + 5'h01;
            n.half   = 1'b0;
            n.sclk_o = lvl_a;
            n.sh_tx  = {r.sh_tx[DATA_W-2:0], 1'b0};
            n.txd_o  = r.sh_tx[DATA_W-2];
          end
        end
      end
      ssp_pkg::SEQ_TAIL: begin
        if (half_tick) begin
          n.seq    = ssp_pkg::SEQ_IDLE;
          n.hold   = r.sh_rx & rmask;
          n.hold_v = 1'b1;
          n.txd_o  = 1'b0;
        end
      end
    endcase

    // Leaving master mode or disabling abandons any frame
    if (!CFG.enable || !CFG.master) begin
      n.seq = ssp_pkg::SEQ_IDLE;
    end

    // Slave engine on synchronised clock and select edges
    if (CFG.enable && !CFG.master) begin
      if (!pulse && r.fs_d && !r.fs_s) begin
        load = 1'b1;
        n.sl_cnt = '0;
      end
      if (samp_edge && sel) begin
        n.sh_rx = {r.sh_rx[DATA_W-2:0], rx_bit};
        if (r.sl_cnt == nbits - 5'h01) begin
          n.hold   = {r.sh_rx[DATA_W-2:0], rx_bit} & rmask;
          n.hold_v = 1'b1;
          n.sl_cnt = '0;
          n.sl_act = 1'b0;
          // Phase 1 keeps select low between words, so reload here
          load     = load | (!pulse && ecpha);
        end else begin
          n.sl_cnt = r.sl_cnt + 5'h01;
        end
      end
      if (pulse && samp_edge && r.fs_s) begin
        load     = 1'b1;
        n.sl_act = 1'b1;
        n.sl_cnt = '0;
      end else if (shft_edge && sel && r.sl_cnt != '0) begin
        n.sh_tx = {r.sh_tx[DATA_W-2:0], 1'b0};
        n.txd_o = r.sh_tx[DATA_W-2];
      end
      if (load) begin
        tx_pop  = tx_valid;
        n.sh_tx = ld_word;
        n.txd_o = ld_word[DATA_W-1];
      end
    end else begin
      n.sl_act = 1'b0;
      n.sl_cnt = '0;
    end

    // Idle-clock timeout in bit periods while receive data waits
    clk_act = (r.seq != ssp_pkg::SEQ_IDLE) | rise | fall;
    if (clk_act || !RX_RVALID) begin
      n.to_cnt = '0;
    end else if (bit_tick && r.to_cnt != TOW'(TIMEOUT_BITS)) begin
      n.to_cnt = r.to_cnt + TOW'(1);
    end

    // Sticky flags: a set in the clearing cycle wins
    if (TIMEOUT_CLR) begin
      n.to_flag = 1'b0;
    end
    if (!clk_act && RX_RVALID && bit_tick && r.to_cnt == TOW'(TIMEOUT_BITS - 1)) begin
      n.to_flag = 1'b1;
    end
    if (OVERRUN_CLR) begin
      n.ov_flag = 1'b0;
    end
    if (r.hold_v && !rx_room) begin
      n.ov_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      r        <= '0;
      r.fsel_o <= ssp_pkg::FSEL_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Status and pins
  // ----------------------------------------------------------------
  // Service levels follow the buffers; the other two are sticky
  assign RAW_STATUS.tx_service = (tx_level <= LW'(ssp_pkg::SVC_LEVEL));
  assign RAW_STATUS.rx_service = (rx_level >= LW'(ssp_pkg::SVC_LEVEL));
  assign RAW_STATUS.timeout    = r.to_flag;
  assign RAW_STATUS.overrun    = r.ov_flag;
  assign MASKED_STATUS = RAW_STATUS & IRQ_MASK;
  assign IRQ           = |MASKED_STATUS;
  assign TX_DMA_REQ    = CFG.enable & ~tx_valid;
  assign BUSY          = (r.seq != ssp_pkg::SEQ_IDLE) | (sel & ~CFG.master);

  // Loopback keeps every pad released so the link sees nothing
  assign PINS_O.sclk_o  = r.sclk_o;
  assign PINS_O.sclk_oe = CFG.enable & CFG.master & ~CFG.loopback;
  assign PINS_O.fsel_o  = r.fsel_o;
  assign PINS_O.fsel_oe = CFG.enable & CFG.master & ~CFG.loopback;
  assign PINS_O.txd_o   = r.txd_o;
  // Pulse format releases data when idle; an SPI or command master drives it low instead
  assign PINS_O.txd_oe  = CFG.enable & ~CFG.loopback &
                          (CFG.master ? (~pulse | (r.seq != ssp_pkg::SEQ_IDLE)) : sel);

endmodule

`default_nettype wire

// ---- include/ssp_pkg.sv ----
// Shared constants and types of the synchronous serial port.
// Assumes a single system clock; pins are sampled by the core itself.
package ssp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W       = 16;  // Widest frame and buffer word
  localparam int FIFO_DEPTH   = 8;   // Entries per buffer
  localparam int HIST_DEPTH   = 8;   // Written words kept for underrun
  localparam int CMD_BITS     = 8;   // Control message length
  localparam int SVC_LEVEL    = 4;   // Service threshold, both buffers

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TIMEOUT_BITS = 32;  // Idle bit periods before timeout
  localparam logic [7:0] PSC_MIN = 8'h02;  // Smallest prescale divisor

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic FSEL_RST = 1'b1;  // Frame select starts deasserted

  // Frame formats
  typedef enum logic [1:0] {
    FMT_PULSE,                       // One-period frame pulse
    FMT_SPI,                         // Active-low select, CPOL/CPHA
    FMT_CMD                          // Half-duplex command-response
  } ssp_fmt_t;

  // Master frame sequencer
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_LEAD,
    SEQ_SLOT,
    SEQ_TAIL
  } ssp_seq_t;

  // Static configuration, same clock domain as the core
  typedef struct packed {
    logic       enable;              // Port on
    logic       master;              // 1: drive clock and select
    logic       loopback;            // Transmit feeds receive
    ssp_fmt_t   fmt;                 // Frame format
    logic       clock_polarity_bit;  // SPI idle clock level
    logic       clock_phase_bit;     // SPI sample on second edge
    logic [3:0] size_m1;             // Frame length minus one (3..15)
    logic [7:0] prescale_divisor;    // Even, 2..254
    logic [7:0] serial_clock_rate;   // Second stage is rate + 1
  } ssp_cfg_t;

  // Interrupt sources, one bit each
  typedef struct packed {
    logic overrun;                   // Receive word lost
    logic timeout;                   // Receive data left idle
    logic rx_service;                // Receive buffer half full
    logic tx_service;                // Transmit buffer half empty
  } ssp_irq_t;

  // Sampled link pins
  typedef struct packed {
    logic sclk;
    logic fsel;
    logic rxd;
  } ssp_pin_in_t;

  // Driven link pins with enables
  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic fsel_o;
    logic fsel_oe;
    logic txd_o;
    logic txd_oe;
  } ssp_pin_out_t;

endpackage

// ---- hdl/ssp_fifo.sv ----
// Synchronous first-in first-out buffer with valid/ready on both sides.
// Assumes one clock; ready on the fill side depends on state only.
`timescale 1ns/1ps
`default_nettype none

module ssp_fifo #(
  parameter int W  = 16,
  parameter int D  = 8,
  parameter int AW = $clog2(D),
  parameter int LW = $clog2(D + 1)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          in_valid,
  input  wire logic [W-1:0]  in_data,
  output logic               in_ready,
  output logic               out_valid,
  output logic [W-1:0]       out_data,
  input  wire logic          out_ready,
  output logic [LW-1:0]      level
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;        // Storage words
    logic [AW-1:0]       wp;         // Next write slot
    logic [AW-1:0]       rp;         // Oldest word
    logic [LW-1:0]       cnt;        // Words held
  } ssp_fifo_st_t;

  ssp_fifo_st_t r;
  ssp_fifo_st_t n;
  logic         push;
  logic         pop;

  // Flags come straight from the count so full and empty are exact
  assign in_ready  = (r.cnt != LW'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rp];
  assign level     = r.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next state
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = (r.wp == AW'(D - 1)) ? '0 : r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + AW'(1);
    end
    n.cnt = r.cnt + LW'(push) - LW'(pop);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule

`default_nettype wire

// ---- dv/ssp_core_assertions.sv ----
// Port-level checker for the serial port core.
// Assumes it is bound into ssp_core; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module ssp_core_assertions #(
  parameter int DATA_W = 16
) (
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire ssp_pkg::ssp_cfg_t     CFG,
  input  wire ssp_pkg::ssp_irq_t     IRQ_MASK,
  input  wire logic                  TX_WVALID,
  input  wire logic                  TX_WREADY,
  input  wire logic                  RX_RVALID,
  input  wire logic [DATA_W-1:0]     RX_RDATA,
  input  wire logic                  RX_RREADY,
  input  wire ssp_pkg::ssp_irq_t     RAW_STATUS,
  input  wire ssp_pkg::ssp_irq_t     MASKED_STATUS,
  input  wire logic                  IRQ,
  input  wire logic                  BUSY,
  input  wire ssp_pkg::ssp_pin_out_t PINS_O
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Head word waiting for the reader
  sequence s_held; RX_RVALID && !RX_RREADY; endsequence
  // Master SPI port with nothing moving
  sequence s_spi_idle;
    CFG.enable && CFG.master && !CFG.loopback && CFG.fmt == ssp_pkg::FMT_SPI && !BUSY;
  endsequence
  property p_mask; MASKED_STATUS == (RAW_STATUS & IRQ_MASK); endproperty
  a_mask: assert property (p_mask) else $error("masked status wrong");
  property p_or; IRQ == (|MASKED_STATUS); endproperty
  a_or: assert property (p_or) else $error("request not OR of sources");
  property p_hold; s_held |=> $stable(RX_RDATA); endproperty
  a_hold: assert property (p_hold) else $error("head word changed unread");
  property p_full; $fell(TX_WREADY) |-> $past(TX_WVALID); endproperty
  a_full: assert property (p_full) else $error("buffer filled without write");
  // Config must hold steady over the cycle that is judged as well
  property p_idle; s_spi_idle ##1 (s_spi_idle and $stable(CFG))
    |-> PINS_O.sclk_o == CFG.clock_polarity_bit; endproperty
  a_idle: assert property (p_idle) else $error("idle clock level wrong");
  property p_sel; PINS_O.fsel_oe && !PINS_O.fsel_o && CFG.fmt == ssp_pkg::FMT_SPI |-> BUSY;
  endproperty
  a_sel: assert property (p_sel) else $error("select low outside frame");
  property p_loop; CFG.enable && CFG.loopback |-> !PINS_O.sclk_oe && !PINS_O.txd_oe;
  endproperty
  a_loop: assert property (p_loop) else $error("pads driven in loopback");
  property p_rxs; RAW_STATUS.rx_service |-> RX_RVALID; endproperty
  a_rxs: assert property (p_rxs) else $error("service with empty buffer");
  property p_tmo; $rose(RAW_STATUS.timeout) |-> $past(RX_RVALID); endproperty
  a_tmo: assert property (p_tmo) else $error("timeout without data");
  property p_frame; $rose(BUSY) |-> ##[1:600] !BUSY; endproperty
  a_frame: assert property (p_frame) else $error("frame too long");
endmodule
bind ssp_core ssp_core_assertions #(.DATA_W(DATA_W)) ssp_core_assertions_i (.*);
`default_nettype wire

// ---- dv/ssp_peer.sv ----
// Off-chip SPI peripheral, polarity 0 and phase 0.
// Assumes the core is master and drives clock and select.
`timescale 1ns/1ps
`default_nettype none
module ssp_peer #(
  parameter int NB = 8  // Frame length in bits
) (
  input  wire logic        sclk,
  input  wire logic        fsel_n,
  input  wire logic        mosi,
  input  wire logic [15:0] reply,
  output logic             miso,
  output logic [15:0]      got
);
  logic [4:0] cnt = 5'h00;  // Bits moved on in this frame
  logic       last = 1'b0;  // Last bit shown, for release
  // Select high rewinds to the MSB; each falling clock steps one bit
  always @(negedge sclk or posedge fsel_n) begin
    if (fsel_n) cnt <= 5'h00;
    else cnt <= cnt + 5'h01;
  end
  always @(posedge fsel_n) last <= (reply[NB-1-cnt] === 1'b1);
  // Sample on first edge
  always @(posedge sclk) if (!fsel_n) got <= {got[14:0], mosi};
  // Released line flips so a stale level never looks valid
  assign miso = fsel_n ? ~last : reply[NB-1-cnt];
endmodule
`default_nettype wire

// ---- dv/sync_serial_port_core_test.sv ----
// Testbench: master SPI frame, loopback fill, status and overrun.
// Assumes ssp_core with a short timeout and the SPI peer model.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_core_test;
  logic clk, rst, wv, wrdy, rvld, rr, tclr, oclr, irq, dma, busy, miso;
  logic [15:0] wd, rdata, got;
  ssp_pkg::ssp_cfg_t cfg;
  ssp_pkg::ssp_irq_t msk, raw, mst;
  ssp_pkg::ssp_pin_in_t pi;
  ssp_pkg::ssp_pin_out_t po;
  int fails, check_count;
  // Wire levels: clock pulled low, select pulled high
  assign pi = {po.sclk_oe & po.sclk_o, ~po.fsel_oe | po.fsel_o, miso};
  ssp_core #(.TIMEOUT_BITS(4)) ssp_core_i (.CLK(clk), .SYS_RST(rst), .CFG(cfg),
    .IRQ_MASK(msk), .TX_WVALID(wv), .TX_WDATA(wd), .TX_WREADY(wrdy), .RX_RVALID(rvld),
    .RX_RDATA(rdata), .RX_RREADY(rr), .TIMEOUT_CLR(tclr), .OVERRUN_CLR(oclr),
    .RAW_STATUS(raw), .MASKED_STATUS(mst), .IRQ(irq), .TX_DMA_REQ(dma), .BUSY(busy),
    .PINS_I(pi), .PINS_O(po));
  ssp_peer ssp_peer_i (.sclk(pi.sclk), .fsel_n(pi.fsel), .mosi(po.txd_o),
    .reply(16'h003C), .miso(miso), .got(got));
  always #25 clk = ~clk;
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task close_out;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bounded edge wait: 0 data ready, 1 timeout, 2 overrun
  task wt(input int c);
    int k;
    k = 0;
    do begin @(posedge clk); k++; end
    while (!(c == 0 ? rvld : c == 1 ? raw.timeout : raw.overrun) && k < 5000);
    if (k >= 5000) begin fails++; close_out; end
  endtask
  // Back-to-back writes; valid held until taken, bounded wait
  task wr_n(input logic [15:0] b, input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      wv <= 1'b1;
      wd <= b + i[15:0];
      k = 0;
      do begin @(posedge clk); k++; end while (!wrdy && k < 5000);
      if (!wrdy) begin fails++; close_out; end
    end
    wv <= 1'b0;
  endtask
  // Pops n words and compares each with b + i
  task rd_n(input logic [15:0] b, input int n);
    rr <= 1'b1;
    for (int i = 0; i < n; i++) begin
      wt(0);
      chk(rdata, b + i[15:0]);
    end
    rr <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_spi;
    cfg.enable <= 1'b1;
    wr_n(16'h01A5, 1);
    repeat (20) @(posedge clk);
    chk(busy, 1'b1);
    wt(0);
    chk(busy, 1'b0);
    chk({8'h00, got[7:0]}, 16'h00A5);
    rd_n(16'h003C, 1);
    $display("t_spi done");
  endtask
  task t_loop;
    cfg.enable <= 1'b0;
    wr_n(16'h0040, 8);
    @(posedge clk);
    chk(wrdy, 1'b0);
    chk(raw.tx_service, 1'b0);
    msk <= 4'hF;
    cfg.enable <= 1'b1;
    cfg.loopback <= 1'b1;
    wt(1);
    chk(raw.rx_service, 1'b1);
    chk(irq, 1'b1);
    chk(dma, 1'b1);
    chk(mst, 16'h0007);
    msk <= 4'h0;
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    chk(raw.timeout, 1'b1);
    tclr <= 1'b1;
    @(posedge clk);
    tclr <= 1'b0;
    @(posedge clk);
    chk(raw.timeout, 1'b0);
    wr_n(16'h00EE, 1);
    wt(2);
    oclr <= 1'b1;
    @(posedge clk);
    oclr <= 1'b0;
    repeat (2) @(posedge clk);
    chk(raw.overrun, 1'b0);
    rd_n(16'h0040, 8);
    @(posedge clk);
    chk(rvld, 1'b0);
    $display("t_loop done");
  endtask
  // Pulse-framed 12-bit word through loopback comes back whole
  task t_pulse;
    cfg.fmt <= ssp_pkg::FMT_PULSE;
    cfg.size_m1 <= 4'hB;
    wr_n(16'h0A5C, 1);
    wt(0);
    rd_n(16'h0A5C, 1);
    $display("t_pulse done");
  endtask
  initial begin
    clk = 0; rst = 1; wv = 0; wd = '0; rr = 0; tclr = 0; oclr = 0; msk = '0;
    cfg = '0; cfg.master = 1'b1; cfg.fmt = ssp_pkg::FMT_SPI; cfg.size_m1 = 4'h7;
    cfg.prescale_divisor = 8'h04; cfg.serial_clock_rate = 8'h03;
    fails = 0; check_count = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({wrdy, rvld, irq}, 16'h0004);
    t_spi;
    t_loop;
    t_pulse;
    close_out;
  end
endmodule
`default_nettype wire
